// File: core/gpr_file.sv
// General register file with hardware link writes and special registers
`timescale 1ns/1ps
`default_nettype none
module gpr_file #(
	parameter int DATA_W = 32,
	parameter int NUM_REGS = 32,
	parameter int IDX_W = 5,
	parameter int MSR_W = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [IDX_W-1:0] rd_a_idx,
	input wire logic [IDX_W-1:0] rd_b_idx,
	output logic [DATA_W-1:0] rd_a_data,
	output logic [DATA_W-1:0] rd_b_data,
	input wire gpr_pkg::ex_write_t ex_wr,
	input wire logic pc_load,
	input wire logic [DATA_W-1:0] pc_load_value,
	input wire logic msr_load,
	input wire logic [MSR_W-1:0] msr_load_value,
	output logic [DATA_W-1:0] pc_value,
	output logic [MSR_W-1:0] msr_before_ex,
	output gpr_pkg::wb_trace_t wb_trace
);
	import gpr_pkg::*;

	initial begin
		if (DATA_W != gpr_pkg::DATA_W || NUM_REGS != gpr_pkg::NUM_REGS)
			$error("gpr_file: width or count differs from package");
		if (IDX_W != gpr_pkg::IDX_W || MSR_W != gpr_pkg::MSR_W)
			$error("gpr_file: index or status width differs from package");
	end

	logic [DATA_W-1:0] regs_reg [NUM_REGS];
	logic [NUM_REGS*DATA_W-1:0] regs_flat;
	logic [DATA_W-1:0] pc_reg;
	logic [MSR_W-1:0] msr_reg;
	logic wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [DATA_W-1:0] wr_data;
	logic [DATA_W-1:0] special_value;

	// ------------------------------------------------------------
	// Write steering
	// ------------------------------------------------------------
	function automatic logic [DATA_W-1:0] spr_read(input spr_sel_t sel,
			input logic [DATA_W-1:0] pc, input logic [MSR_W-1:0] msr);
		spr_read = (sel == SPR_PC) ? pc : {{(DATA_W-MSR_W){1'b0}}, msr};
	endfunction : spr_read

	assign special_value = spr_read(ex_wr.spr, pc_reg, msr_reg);

	always_comb begin
		wr_en = 1'b1;
		wr_idx = ex_wr.dest;
		wr_data = ex_wr.data;
		unique case (ex_wr.kind)
			WR_NONE: begin
				wr_en = 1'b0;
			end
			WR_ALU: begin
				wr_idx = ex_wr.dest;
			end
			WR_LINK_CALL: begin
				wr_idx = SUB_LINK_IDX;
				wr_data = pc_reg;
			end
			WR_LINK_INT: begin
				wr_idx = INT_LINK_IDX;
				wr_data = ex_wr.ret_addr;
			end
			WR_LINK_TRAP: begin
				wr_idx = TRAP_LINK_IDX;
				wr_data = ex_wr.ret_addr;
			end
			WR_LINK_EXC: begin
				wr_idx = EXC_LINK_IDX;
				wr_data = ex_wr.ret_addr;
			end
			WR_FROM_SPECIAL: begin
				wr_data = special_value;
			end
			default: begin
				wr_en = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Register array
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_reg[i] <= DATA_RESET;
		end else if (ce && wr_en && wr_idx != ZERO_IDX) begin
			regs_reg[wr_idx] <= wr_data;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_REGS; i++)
			regs_flat[i*DATA_W +: DATA_W] = regs_reg[i];
	end

	gpr_read_port #(.DATA_W(DATA_W), .NUM_REGS(NUM_REGS), .IDX_W(IDX_W)) u_rd_a (
		.regs_flat(regs_flat),
		.idx(rd_a_idx),
		.data(rd_a_data)
	);

	gpr_read_port #(.DATA_W(DATA_W), .NUM_REGS(NUM_REGS), .IDX_W(IDX_W)) u_rd_b (
		.regs_flat(regs_flat),
		.idx(rd_b_idx),
		.data(rd_b_data)
	);

	// ------------------------------------------------------------
	// Special registers outside the array
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pc_reg <= PC_RESET;
		else if (ce && pc_load)
			pc_reg <= pc_load_value;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			msr_reg <= MSR_RESET;
		else if (ce && msr_load)
			msr_reg <= msr_load_value;
	end

	assign pc_value = pc_reg;
	assign msr_before_ex = msr_reg;

	// ------------------------------------------------------------
	// Write trace
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_trace <= '0;
		end else if (ce) begin
			wb_trace.valid <= wr_en && wr_idx != ZERO_IDX;
			wb_trace.dest <= wr_idx;
			wb_trace.value <= wr_data;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_link_int;
		ce && ex_wr.kind == WR_LINK_INT;
	endsequence

	property p_zero_read;
		@(posedge clk) disable iff (rst)
		rd_a_idx == ZERO_IDX |-> rd_a_data == '0;
	endproperty
	a_zero_read: assert property (p_zero_read) else $error("zero_reg read nonzero");

	property p_zero_write;
		@(posedge clk) disable iff (rst)
		ce && wr_en && wr_idx == ZERO_IDX |=> !wb_trace.valid && regs_reg[ZERO_IDX] == DATA_RESET;
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero_reg write kept");

	property p_int_link;
		@(posedge clk) disable iff (rst)
		s_link_int |=> regs_reg[INT_LINK_IDX] == $past(ex_wr.ret_addr);
	endproperty
	a_int_link: assert property (p_int_link) else $error("interrupt link not written");

	property p_trap_link;
		@(posedge clk) disable iff (rst)
		ce && ex_wr.kind == WR_LINK_TRAP |=> regs_reg[TRAP_LINK_IDX] == $past(ex_wr.ret_addr);
	endproperty
	a_trap_link: assert property (p_trap_link) else $error("trap link not written");

	property p_exc_link;
		@(posedge clk) disable iff (rst)
		ce && ex_wr.kind == WR_LINK_EXC |=> regs_reg[EXC_LINK_IDX] == $past(ex_wr.ret_addr);
	endproperty
	a_exc_link: assert property (p_exc_link) else $error("exception link not written");

	property p_call_link;
		@(posedge clk) disable iff (rst)
		ce && ex_wr.kind == WR_LINK_CALL |=> regs_reg[SUB_LINK_IDX] == $past(pc_reg);
	endproperty
	a_call_link: assert property (p_call_link) else $error("call link not pc");

	property p_msr_before;
		@(posedge clk) disable iff (rst)
		ce && msr_load |=> msr_before_ex == $past(msr_load_value);
	endproperty
	a_msr_before: assert property (p_msr_before) else $error("status value wrong");

	property p_dest_write;
		@(posedge clk) disable iff (rst)
		ce && ex_wr.kind == WR_ALU && ex_wr.dest != ZERO_IDX
			|=> wb_trace.valid && wb_trace.dest == $past(ex_wr.dest)
				&& regs_reg[$past(ex_wr.dest)] == $past(ex_wr.data);
	endproperty
	a_dest_write: assert property (p_dest_write) else $error("destination write lost");

	property p_mfs;
		@(posedge clk) disable iff (rst)
		ce && ex_wr.kind == WR_FROM_SPECIAL && ex_wr.spr == SPR_PC && ex_wr.dest != ZERO_IDX
			|=> wb_trace.value == $past(pc_reg);
	endproperty
	a_mfs: assert property (p_mfs) else $error("special move wrong value");

	property p_hold;
		@(posedge clk) disable iff (rst)
		!ce |=> $stable(pc_reg) && $stable(msr_reg) && $stable(wb_trace);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved while frozen");
endmodule : gpr_file
`default_nettype wire

// File: core/gpr_pkg.sv
// Constants and carrier types for the general register file
//
// How it works
// - Thirty-two general registers; index 0 always reads zero and drops writes, the rest usable as source or destination operand.
// - Taken interrupt writes return address into interrupt_link_reg, index 14.
// - Taken debugger trap writes return address into trap_link_reg, index 16.
// - Taken exception writes return address into exception_link_reg, index 17.
// - Branch-and-link stores current program counter into subroutine_link_reg, index 15.
// - Program counter and status register live outside; special moves copy them.
// - Status register is ten bits; exposed as it stood before the execute instruction.
// - Execute-stage destination is chosen by a five-bit register index.
package gpr_pkg;
	localparam int DATA_W = 32;
	localparam int NUM_REGS = 32;
	localparam int IDX_W = 5;
	localparam int MSR_W = 10;
	localparam logic [IDX_W-1:0] ZERO_IDX = 5'h00;
	localparam logic [IDX_W-1:0] INT_LINK_IDX = 5'h0E;
	localparam logic [IDX_W-1:0] SUB_LINK_IDX = 5'h0F;
	localparam logic [IDX_W-1:0] TRAP_LINK_IDX = 5'h10;
	localparam logic [IDX_W-1:0] EXC_LINK_IDX = 5'h11;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
	localparam logic [MSR_W-1:0] MSR_RESET = 10'h000;
	localparam logic [DATA_W-1:0] PC_RESET = 32'h00000000;

	// Execute-stage write source
	typedef enum logic [2:0] {
		WR_NONE,
		WR_ALU,
		WR_LINK_CALL,
		WR_LINK_INT,
		WR_LINK_TRAP,
		WR_LINK_EXC,
		WR_FROM_SPECIAL
	} wr_kind_t;

	// Special register selector for special moves
	typedef enum logic {
		SPR_PC,
		SPR_MSR
	} spr_sel_t;

	typedef struct packed {
		wr_kind_t kind;
		logic [IDX_W-1:0] dest;
		logic [DATA_W-1:0] data;
		logic [DATA_W-1:0] ret_addr;
		spr_sel_t spr;
	} ex_write_t;

	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] dest;
		logic [DATA_W-1:0] value;
	} wb_trace_t;
endpackage : gpr_pkg

// File: core/gpr_read_port.sv
// One combinational read port of the general register file
`timescale 1ns/1ps
`default_nettype none
module gpr_read_port #(
	parameter int DATA_W = 32,
	parameter int NUM_REGS = 32,
	parameter int IDX_W = 5
) (
	input wire logic [NUM_REGS*DATA_W-1:0] regs_flat,
	input wire logic [IDX_W-1:0] idx,
	output logic [DATA_W-1:0] data
);
	import gpr_pkg::*;

	initial begin
		if (NUM_REGS != (1 << IDX_W))
			$error("gpr_read_port: NUM_REGS must equal 2**IDX_W");
	end

	always_comb begin
		if (idx == ZERO_IDX)
			data = '0;
		else
			data = regs_flat[idx*DATA_W +: DATA_W];
	end
endmodule : gpr_read_port
`default_nettype wire

// File: tb/test_soft_cpu_gpr_file.sv
// Self-checking testbench for the general register file
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module test_soft_cpu_gpr_file;
	import gpr_pkg::*;
	logic clk;
	logic rst;
	logic ce;
	logic [IDX_W-1:0] rd_a_idx;
	logic [IDX_W-1:0] rd_b_idx;
	logic [DATA_W-1:0] rd_a_data;
	logic [DATA_W-1:0] rd_b_data;
	ex_write_t ex_wr;
	logic pc_load;
	logic [DATA_W-1:0] pc_load_value;
	logic msr_load;
	logic [MSR_W-1:0] msr_load_value;
	logic [DATA_W-1:0] pc_value;
	logic [MSR_W-1:0] msr_before_ex;
	wb_trace_t wb_trace;
	int num_errors = 0;
	int samples_checked = 0;

	gpr_file dut (.clk(clk), .rst(rst), .ce(ce), .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx),
		.rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .ex_wr(ex_wr), .pc_load(pc_load),
		.pc_load_value(pc_load_value), .msr_load(msr_load), .msr_load_value(msr_load_value),
		.pc_value(pc_value), .msr_before_ex(msr_before_ex), .wb_trace(wb_trace));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	// Present one request across one rising edge; it stays up until replaced
	task issue(input ex_write_t w);
		ex_wr = w;
		@(negedge clk);
	endtask : issue

	// Drop all requests and let one edge pass
	task idle;
		ex_wr = '0;
		pc_load = 1'b0;
		msr_load = 1'b0;
		@(negedge clk);
	endtask : idle

	task chk_rd(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] e);
		rd_a_idx = i;
		rd_b_idx = i;
		#1;
		`CHK("rd_a_data", e, rd_a_data)
		`CHK("rd_b_data", e, rd_b_data)
		@(negedge clk);
	endtask : chk_rd

	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		`CHK("pc_value", PC_RESET, pc_value)
		`CHK("msr_before_ex", MSR_RESET, msr_before_ex)
		`CHK("wb_trace", 38'h0, wb_trace)
		chk_rd(5'h05, DATA_RESET);
	endtask : t_reset

	// Every index written back to back, zero index dropped
	task t_all_regs;
		for (int i = 0; i < NUM_REGS; i++) begin
			issue('{WR_ALU, i[4:0], 32'hA5A50000 + i, 32'h0, SPR_PC});
			`CHK("wb_valid", (i != 0), wb_trace.valid)
			`CHK("wb_dest", i[4:0], wb_trace.dest)
			if (i != 0)
				`CHK("wb_value", 32'hA5A50000 + i, wb_trace.value)
		end
		idle();
		for (int i = 0; i < NUM_REGS; i++) begin
			chk_rd(i[4:0], (i == 0) ? 32'h0 : 32'hA5A50000 + i);
		end
	endtask : t_all_regs

	// Hardware link writes ignore dest
	task t_links;
		pc_load = 1'b1;
		pc_load_value = 32'h00001230;
		issue('{WR_LINK_INT, 5'h03, 32'h0, 32'h0000AB14, SPR_PC});
		`CHK("pc_value", 32'h00001230, pc_value)
		pc_load = 1'b0;
		issue('{WR_LINK_TRAP, 5'h03, 32'h0, 32'h0000AB16, SPR_PC});
		issue('{WR_LINK_EXC, 5'h03, 32'h0, 32'h0000AB17, SPR_PC});
		// Link call and a pc load together: the old pc is linked
		pc_load = 1'b1;
		pc_load_value = 32'h00002460;
		issue('{WR_LINK_CALL, 5'h03, 32'h0, 32'hFFFFFFFF, SPR_PC});
		`CHK("wb_dest", SUB_LINK_IDX, wb_trace.dest)
		`CHK("wb_value", 32'h00001230, wb_trace.value)
		`CHK("pc_value", 32'h00002460, pc_value)
		idle();
		chk_rd(INT_LINK_IDX, 32'h0000AB14);
		chk_rd(TRAP_LINK_IDX, 32'h0000AB16);
		chk_rd(EXC_LINK_IDX, 32'h0000AB17);
		chk_rd(SUB_LINK_IDX, 32'h00001230);
		chk_rd(5'h03, 32'hA5A50003);
	endtask : t_links

	// Special moves, status timing and clock enable hold
	task t_special;
		msr_load = 1'b1;
		msr_load_value = 10'h2A5;
		issue('{WR_FROM_SPECIAL, 5'h08, 32'h0, 32'h0, SPR_MSR});
		`CHK("msr_before_ex", 10'h2A5, msr_before_ex)
		idle();
		chk_rd(5'h08, 32'h0);
		issue('{WR_FROM_SPECIAL, 5'h09, 32'h0, 32'h0, SPR_MSR});
		issue('{WR_FROM_SPECIAL, 5'h0A, 32'h0, 32'h0, SPR_PC});
		issue('{WR_FROM_SPECIAL, 5'h00, 32'h0, 32'h0, SPR_PC});
		`CHK("wb_valid", 1'b0, wb_trace.valid)
		idle();
		chk_rd(5'h09, 32'h000002A5);
		chk_rd(5'h0A, 32'h00002460);
		chk_rd(ZERO_IDX, 32'h0);
		ce = 1'b0;
		pc_load = 1'b1;
		pc_load_value = 32'h0000BEEF;
		msr_load = 1'b1;
		msr_load_value = 10'h155;
		issue('{WR_ALU, 5'h09, 32'hFFFFFFFF, 32'h0, SPR_PC});
		`CHK("pc_value", 32'h00002460, pc_value)
		`CHK("msr_before_ex", 10'h2A5, msr_before_ex)
		`CHK("wb_valid", 1'b0, wb_trace.valid)
		ce = 1'b1;
		idle();
		chk_rd(5'h09, 32'h000002A5);
	endtask : t_special

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		rd_a_idx = '0;
		rd_b_idx = '0;
		ex_wr = '0;
		pc_load = 1'b0;
		pc_load_value = '0;
		msr_load = 1'b0;
		msr_load_value = '0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_all_regs();
		t_links();
		t_special();
		finish_test();
	end
endmodule : test_soft_cpu_gpr_file
`default_nettype wire
